/* rtl/pllc_map.svh */
// Register map, field positions, reset values and counts of the loop block
`ifndef PLLC_MAP_SVH
`define PLLC_MAP_SVH

// Byte addresses of the word-aligned registers
`define PLLC_ADR_LOOP_CTL   8'h00
`define PLLC_ADR_BW_CTL     8'h04
`define PLLC_ADR_FB_HIGH    8'h08
`define PLLC_ADR_FB_LOW     8'h0C
`define PLLC_ADR_VCO_RANGE  8'h10
`define PLLC_ADR_REF_DIV    8'h14

// Loop control register fields
`define PLLC_LC_IRQ_EN      7
`define PLLC_LC_FLAG        6
`define PLLC_LC_PON         5
`define PLLC_LC_SEL         4
`define PLLC_LC_PRE_HI      3
`define PLLC_LC_PRE_LO      2
`define PLLC_LC_VPR_HI      1
`define PLLC_LC_VPR_LO      0

// Bandwidth control register fields
`define PLLC_BW_AUTO        7
`define PLLC_BW_LOCK        6
`define PLLC_BW_PHASE       5

// Reset values
`define PLLC_RST_FB_HIGH    4'h0
`define PLLC_RST_FB_LOW     8'h40
`define PLLC_RST_VCO_RANGE  8'h40
`define PLLC_RST_REF_DIV    4'h1

// Source edges to wait on each side of a switch-over
`define PLLC_SWITCH_EDGES   2'h3

`endif

/* rtl/pllc_pkg.sv */
// Types used by the clock selector of the loop control block
package pllc_pkg;

   // Clock selector states
   typedef enum logic {
      PLLC_SEL_RUN,
      PLLC_SEL_HOLD
   } pllc_sel_state_type;

endpackage : pllc_pkg

/* rtl/pllc_sel_if.sv */
// Link between the register logic and the base clock selector
`timescale 1ns/1ps

interface pllc_sel_if;
   logic sel;       // Requested source, 1 = VCO clock
   logic loop_en;   // Loop running, VCO clock present
   logic base_clk;  // Divided base clock
   logic busy;      // Switch-over in progress

   // Register side
   modport ctl (output sel, output loop_en, input base_clk, input busy);
   // Selector side
   modport sel_end (input sel, input loop_en, output base_clk, output busy);
endinterface : pllc_sel_if

/* rtl/pllc_clk_sel.sv */
// Base clock selector: source sampling, switch-over hold and divide by two
`timescale 1ns/1ps
`include "pllc_map.svh"

module pllc_clk_sel (
   input  wire logic clk_i,        // System clock
   input  wire logic rst_i,        // Synchronous reset
   input  wire logic osc_clock_i,  // Oscillator clock pin
   input  wire logic vco_clock_i,  // VCO clock pin
   pllc_sel_if.sel_end sel_if      // Register side link
);

   // Two-stage samplers and edge history for both sources
   logic       osc_s1_q, osc_s2_q, osc_s3_q;
   logic       vco_s1_q, vco_s2_q, vco_s3_q;
   logic       osc_rise, vco_rise;          // Rising edge seen
   logic       cur_sel_q;                   // Source now in use
   logic [1:0] osc_cnt_q, vco_cnt_q;        // Edges counted in hold
   logic       out_q;                       // Divided output
   pllc_pkg::pllc_sel_state_type state_q;   // Selector state

   // Samplers; first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
         vco_s1_q <= 1'b0;
         vco_s2_q <= 1'b0;
         vco_s3_q <= 1'b0;
      end else begin
         osc_s1_q <= osc_clock_i;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
         vco_s1_q <= vco_clock_i;
         vco_s2_q <= vco_s1_q;
         vco_s3_q <= vco_s2_q;
      end
   end

   assign osc_rise = osc_s2_q & ~osc_s3_q;
   assign vco_rise = vco_s2_q & ~vco_s3_q;

   // Switch-over sequencing; stopped VCO counts as done
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q   <= pllc_pkg::PLLC_SEL_RUN;
         cur_sel_q <= 1'b0;
         osc_cnt_q <= 2'h0;
         vco_cnt_q <= 2'h0;
      end else begin
         case (state_q)
            pllc_pkg::PLLC_SEL_RUN: begin
               // New source requested: freeze the output
               if (sel_if.sel != cur_sel_q) begin
                  state_q   <= pllc_pkg::PLLC_SEL_HOLD; // see [RULE8]
                  osc_cnt_q <= 2'h0;
                  vco_cnt_q <= 2'h0;
               end
            end
            pllc_pkg::PLLC_SEL_HOLD: begin
               // Count source edges up to the limit
               if (osc_rise && osc_cnt_q != `PLLC_SWITCH_EDGES) begin
                  osc_cnt_q <= osc_cnt_q + 2'h1;
               end
               if (vco_rise && vco_cnt_q != `PLLC_SWITCH_EDGES) begin
                  vco_cnt_q <= vco_cnt_q + 2'h1;
               end
               // Oscillator, and VCO unless loop is off, seen enough edges: take new source
               if (osc_cnt_q == `PLLC_SWITCH_EDGES &&
                   (vco_cnt_q == `PLLC_SWITCH_EDGES ||
                    !sel_if.loop_en)) begin
                  cur_sel_q <= sel_if.sel;            // see [RULE8]
                  state_q   <= pllc_pkg::PLLC_SEL_RUN;
               end
            end
            default: begin
               state_q <= pllc_pkg::PLLC_SEL_RUN;
            end
         endcase
      end
   end

   // Divide the selected source by two, static during hold
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_q <= 1'b0;
      end else if (state_q == pllc_pkg::PLLC_SEL_RUN &&
                   sel_if.sel == cur_sel_q) begin
         if (cur_sel_q ? vco_rise : osc_rise) begin
            out_q <= ~out_q;                          // see [RULE6]
         end
      end
   end

   assign sel_if.base_clk = out_q;
   assign sel_if.busy     = (state_q == pllc_pkg::PLLC_SEL_HOLD);

   // Output frozen while a switch-over is pending
   a_hold_static: assert property ( // see [RULE8]
      @(posedge clk_i) disable iff (rst_i)
      sel_if.busy |=> $stable(out_q))
      else $error("base clock moved during switch-over");

   // Each rising edge of the running oscillator source toggles the output
   a_div_two: assert property ( // see [RULE6]
      @(posedge clk_i) disable iff (rst_i)
      (state_q == pllc_pkg::PLLC_SEL_RUN && sel_if.sel == cur_sel_q &&
       !cur_sel_q && osc_rise) |=> (out_q != $past(out_q)))
      else $error("base clock did not toggle on source edge");

endmodule : pllc_clk_sel

/* rtl/pllc_top.sv */
// Register block and control logic of the loop clock generator
//
// Notes on behaviour
// [RULE1] Irq enable writable only in auto mode
// [RULE2] Lock change sets flag; flag and enable interrupt
// [RULE3] Flag reads zero and clears in manual mode
// [RULE4] Reading loop control clears the flag
// [RULE5] Power-on bit cannot clear while VCO selected
// [RULE6] Base clock is selected source halved
// [RULE7] Source select cannot set while loop off
// [RULE8] Output held static during source switch-over
// [RULE9] Bus scaler field protected while loop on
// [RULE10] VCO power range protected while loop on
// [RULE11] Software never writes range exponent three
// [RULE12] Auto bit selects bandwidth mode, reset manual
// [RULE13] Lock indicator valid in auto, zero otherwise
// [RULE14] Software writes zero to lock position
// [RULE15] Phase bit: status in auto, control manual
// [RULE16] Manual phase value kept across auto mode
// [RULE17] Feedback factor zero acts as one
// [RULE18] Feedback factor resets to 64, protected
// [RULE19] Zero range factor disables loop, deselects VCO
// [RULE20] Range factor resets to 64
// [RULE21] Divider factor protected, zero acts as one
// [RULE22] Divider factor resets to one
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pllc_map.svh"

module pllc_top (
   input  wire logic        clk_i,               // 50 MHz system clock
   input  wire logic        rst_i,               // Synchronous reset
   input  wire logic        wb_cyc_i,            // Bus cycle
   input  wire logic        wb_stb_i,            // Bus strobe
   input  wire logic        wb_we_i,             // Write enable
   input  wire logic [7:0]  wb_adr_i,            // Byte address
   input  wire logic [3:0]  wb_sel_i,            // Byte lanes
   input  wire logic [31:0] wb_dat_i,            // Write data
   output logic      [31:0] wb_dat_o,            // Read data
   output logic             wb_ack_o,            // Acknowledge
   input  wire logic        osc_clock_i,         // Oscillator clock
   input  wire logic        vco_clock_i,         // VCO clock
   input  wire logic        lock_detect_i,       // Analog lock detect
   input  wire logic        track_detect_i,      // Analog tracking state
   output logic             base_clock_out_o,    // Base clock
   output logic             irq_o,               // Interrupt request
   output logic             loop_enable_o,       // Loop running
   output logic      [1:0]  bus_scaler_sel_o,    // Prescaler code
   output logic      [1:0]  vco_power_range_o,   // Range exponent
   output logic      [11:0] feedback_factor_o,   // Effective multiplier
   output logic      [7:0]  vco_range_factor_o,  // Range multiplier
   output logic      [3:0]  ref_divider_factor_o,// Effective divider
   output logic             bandwidth_auto_o,    // Auto bandwidth mode
   output logic             bandwidth_phase_o    // Phase bit as read, to loop
);

   // Software-visible state
   logic        lock_change_irq_en_q;   // Interrupt enable
   logic        lock_change_flag_q;     // Lock change flag
   logic        loop_power_on_q;        // Loop on
   logic        base_source_select_q;   // 1 = VCO clock
   logic [1:0]  bus_scaler_sel_q;       // Prescaler code
   logic [1:0]  vco_power_range_q;      // Range exponent
   logic        auto_q;                 // Auto bandwidth
   logic        lock_q;                 // Lock indicator
   logic        phase_manual_q;         // Stored manual phase
   logic [3:0]  fb_high_q;              // Feedback factor bits 11:8
   logic [7:0]  fb_low_q;               // Feedback factor bits 7:0
   logic [7:0]  vco_range_factor_q;     // Range factor
   logic [3:0]  ref_divider_factor_q;   // Reference divider

   // Pin samplers
   logic        lock_s1_q, lock_s2_q;   // Lock detect sampler
   logic        track_s1_q, track_s2_q; // Tracking sampler

   // Bus decode
   logic        req;                    // Request present
   logic        wr_lo;                  // Write of low lane taken
   logic        rd_take;                // Read data latched now
   logic [7:0]  wd;                     // Low lane write data
   logic [7:0]  rdata;                  // Selected read value
   logic        lock_d;                 // Next lock indicator
   logic        lock_toggle;            // Lock indicator changes
   logic        phase_read;             // Phase bit as read
   logic        range_zero;             // Range factor is zero

   pllc_sel_if sel_if ();

   // Base clock selector
   pllc_clk_sel u_clk_sel (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .osc_clock_i (osc_clock_i),
      .vco_clock_i (vco_clock_i),
      .sel_if      (sel_if)
   );

   assign sel_if.sel     = base_source_select_q;
   assign sel_if.loop_en = loop_enable_o;

   // Request decode; writes land on the edge that sees ack
   assign req        = wb_cyc_i & wb_stb_i;
   assign wr_lo      = req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign rd_take    = req & ~wb_we_i & ~wb_ack_o;
   assign wd         = wb_dat_i[7:0];
   assign range_zero = (vco_range_factor_q == 8'h00);
   assign lock_d     = auto_q & lock_s2_q;                // see [RULE13]
   assign lock_toggle = auto_q & (lock_d != lock_q);
   assign phase_read = auto_q ? track_s2_q : phase_manual_q; // see [RULE15]

   // Pin samplers; first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_s1_q  <= 1'b0;
         lock_s2_q  <= 1'b0;
         track_s1_q <= 1'b0;
         track_s2_q <= 1'b0;
      end else begin
         lock_s1_q  <= lock_detect_i;
         lock_s2_q  <= lock_s1_q;
         track_s1_q <= track_detect_i;
         track_s2_q <= track_s1_q;
      end
   end

   // Read value mux, reserved bits zero
   always_comb begin
      rdata = 8'h00;
      case (wb_adr_i)
         `PLLC_ADR_LOOP_CTL: begin
            rdata[`PLLC_LC_IRQ_EN] = lock_change_irq_en_q & auto_q;
            rdata[`PLLC_LC_FLAG]   = lock_change_flag_q & auto_q; // see [RULE3]
            rdata[`PLLC_LC_PON]    = loop_power_on_q;
            rdata[`PLLC_LC_SEL]    = base_source_select_q;
            rdata[`PLLC_LC_PRE_HI:`PLLC_LC_PRE_LO] = bus_scaler_sel_q;
            rdata[`PLLC_LC_VPR_HI:`PLLC_LC_VPR_LO] = vco_power_range_q;
         end
         `PLLC_ADR_BW_CTL: begin
            rdata[`PLLC_BW_AUTO]  = auto_q;
            rdata[`PLLC_BW_LOCK]  = lock_q;
            rdata[`PLLC_BW_PHASE] = phase_read;
         end
         `PLLC_ADR_FB_HIGH:   rdata = {4'h0, fb_high_q};
         `PLLC_ADR_FB_LOW:    rdata = fb_low_q;
         `PLLC_ADR_VCO_RANGE: rdata = vco_range_factor_q;
         `PLLC_ADR_REF_DIV:   rdata = {4'h0, ref_divider_factor_q};
         default:             rdata = 8'h00;
      endcase
   end

   // Bus slave: ack one cycle after request, drop after one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (rd_take) begin
            wb_dat_o <= {24'h00_0000, rdata};
         end
      end
   end

   // Interrupt enable, writable and held only in auto mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_change_irq_en_q <= 1'b0;                    // see [RULE1]
      end else if (!auto_q) begin
         lock_change_irq_en_q <= 1'b0;                    // see [RULE1]
      end else if (wr_lo && wb_adr_i == `PLLC_ADR_LOOP_CTL) begin
         lock_change_irq_en_q <= wd[`PLLC_LC_IRQ_EN];
      end
   end

   // Lock indicator follows the detector only in auto mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= lock_d;                                // see [RULE13]
      end
   end

   // Flag: set on lock change, cleared by reading; set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_change_flag_q <= 1'b0;
      end else if (!auto_q) begin
         lock_change_flag_q <= 1'b0;                      // see [RULE3]
      end else if (lock_toggle) begin
         lock_change_flag_q <= 1'b1;                      // see [RULE2]
      end else if (rd_take && wb_adr_i == `PLLC_ADR_LOOP_CTL) begin
         lock_change_flag_q <= 1'b0;                      // see [RULE4]
      end
   end

   // Loop on and source select with their mutual interlock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_power_on_q      <= 1'b1;                    // see [RULE5]
         base_source_select_q <= 1'b0;                    // see [RULE6]
      end else begin
         if (wr_lo && wb_adr_i == `PLLC_ADR_LOOP_CTL) begin
            // Clear refused while the VCO clock is selected
            if (wd[`PLLC_LC_PON] || !base_source_select_q) begin
               loop_power_on_q <= wd[`PLLC_LC_PON];       // see [RULE5]
            end
            // Set refused while the loop is off or range is zero
            if (!wd[`PLLC_LC_SEL] ||
                (loop_power_on_q && !range_zero)) begin
               base_source_select_q <= wd[`PLLC_LC_SEL];  // see [RULE7]
            end
         end
         if (range_zero) begin
            base_source_select_q <= 1'b0;                 // see [RULE19]
         end
      end
   end

   // Prescaler and range exponent, frozen while the loop is on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_scaler_sel_q  <= 2'h0;
         vco_power_range_q <= 2'h0;
      end else if (wr_lo && wb_adr_i == `PLLC_ADR_LOOP_CTL &&
                   !loop_power_on_q) begin
         bus_scaler_sel_q  <= wd[`PLLC_LC_PRE_HI:`PLLC_LC_PRE_LO]; // see [RULE9]
         vco_power_range_q <= wd[`PLLC_LC_VPR_HI:`PLLC_LC_VPR_LO]; // see [RULE10]
      end
   end

   // Bandwidth mode and the manual phase store
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         auto_q         <= 1'b0;                          // see [RULE12]
         phase_manual_q <= 1'b0;                          // see [RULE15]
      end else if (wr_lo && wb_adr_i == `PLLC_ADR_BW_CTL) begin
         auto_q <= wd[`PLLC_BW_AUTO];                     // see [RULE12]
         // Phase written only in manual mode; kept during auto
         if (!auto_q) begin
            phase_manual_q <= wd[`PLLC_BW_PHASE];         // see [RULE16]
         end
      end
   end

   // Divider factors, all frozen while the loop is on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fb_high_q            <= `PLLC_RST_FB_HIGH;       // see [RULE18]
         fb_low_q             <= `PLLC_RST_FB_LOW;        // see [RULE18]
         vco_range_factor_q   <= `PLLC_RST_VCO_RANGE;     // see [RULE20]
         ref_divider_factor_q <= `PLLC_RST_REF_DIV;       // see [RULE22]
      end else if (wr_lo && !loop_power_on_q) begin
         case (wb_adr_i)
            `PLLC_ADR_FB_HIGH:   fb_high_q <= wd[3:0];    // see [RULE18]
            `PLLC_ADR_FB_LOW:    fb_low_q  <= wd;         // see [RULE18]
            `PLLC_ADR_VCO_RANGE: vco_range_factor_q <= wd; // see [RULE19]
            `PLLC_ADR_REF_DIV:   ref_divider_factor_q <= wd[3:0]; // see [RULE21]
            default: begin
            end
         endcase
      end
   end

   // Registered outputs to the analog loop and the system
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o                <= 1'b0;
         loop_enable_o        <= 1'b0;
         base_clock_out_o     <= 1'b0;
         bus_scaler_sel_o     <= 2'h0;
         vco_power_range_o    <= 2'h0;
         feedback_factor_o    <= 12'h001;
         vco_range_factor_o   <= 8'h00;
         ref_divider_factor_o <= 4'h1;
         bandwidth_auto_o     <= 1'b0;
         bandwidth_phase_o    <= 1'b0;
      end else begin
         irq_o <= lock_change_flag_q & lock_change_irq_en_q; // see [RULE2]
         // Zero range factor keeps the loop disabled
         loop_enable_o     <= loop_power_on_q & ~range_zero; // see [RULE19]
         base_clock_out_o  <= sel_if.base_clk;            // see [RULE6]
         bus_scaler_sel_o  <= bus_scaler_sel_q;
         vco_power_range_o <= vco_power_range_q;
         // Zero multiplier behaves as one
         if ({fb_high_q, fb_low_q} == 12'h000) begin
            feedback_factor_o <= 12'h001;                 // see [RULE17]
         end else begin
            feedback_factor_o <= {fb_high_q, fb_low_q};
         end
         vco_range_factor_o <= vco_range_factor_q;
         // Zero divider behaves as one
         if (ref_divider_factor_q == 4'h0) begin
            ref_divider_factor_o <= 4'h1;                 // see [RULE21]
         end else begin
            ref_divider_factor_o <= ref_divider_factor_q;
         end
         bandwidth_auto_o  <= auto_q;
         bandwidth_phase_o <= phase_read;
      end
   end

   // Enable never survives manual mode
   a_irq_en_manual: assert property ( // see [RULE1]
      @(posedge clk_i) disable iff (rst_i)
      !auto_q |=> !lock_change_irq_en_q)
      else $error("irq enable set in manual mode");

   // Lock change raises the flag on the next edge
   a_flag_on_lock: assert property ( // see [RULE2]
      @(posedge clk_i) disable iff (rst_i)
      lock_toggle |=> lock_change_flag_q)
      else $error("lock change did not set flag");

   // Interrupt output follows flag and enable by one cycle
   a_irq_follow: assert property ( // see [RULE2]
      @(posedge clk_i) disable iff (rst_i)
      (lock_change_flag_q && lock_change_irq_en_q) |=> irq_o)
      else $error("interrupt not raised");

   // Flag and lock stay low while manual
   a_manual_quiet: assert property ( // see [RULE3]
      @(posedge clk_i) disable iff (rst_i)
      !auto_q |=> (!lock_change_flag_q && !lock_q))
      else $error("flag or lock set in manual mode");

   // Read of loop control without new change clears flag
   a_read_clear: assert property ( // see [RULE4]
      @(posedge clk_i) disable iff (rst_i)
      (rd_take && wb_adr_i == `PLLC_ADR_LOOP_CTL && !lock_toggle)
      |=> !lock_change_flag_q)
      else $error("flag survived a read");

   // Loop stays on while VCO clock is selected
   a_pon_locked: assert property ( // see [RULE5]
      @(posedge clk_i) disable iff (rst_i)
      (loop_power_on_q && base_source_select_q) |=> loop_power_on_q)
      else $error("loop turned off with VCO selected");

   // Source select only rises with loop already on
   a_sel_needs_pon: assert property ( // see [RULE7]
      @(posedge clk_i) disable iff (rst_i)
      $rose(base_source_select_q) |-> $past(loop_power_on_q))
      else $error("VCO selected with loop off");

   // Zero range factor forces oscillator source
   a_range_zero: assert property ( // see [RULE19]
      @(posedge clk_i) disable iff (rst_i)
      range_zero |=> (!base_source_select_q ##1 !loop_enable_o))
      else $error("zero range factor did not disable");

   // Factors frozen while the loop is on
   a_protect: assert property ( // see [RULE18]
      @(posedge clk_i) disable iff (rst_i)
      loop_power_on_q |=> ($stable(fb_high_q) && $stable(fb_low_q) &&
                           $stable(vco_range_factor_q) &&
                           $stable(ref_divider_factor_q)))
      else $error("factor changed while loop on");

   // Bus answers one cycle after request, for one cycle
   a_wb_ack: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (req && !wb_ack_o) |=> (wb_ack_o ##1 !wb_ack_o))
      else $error("bus acknowledge timing wrong");

endmodule : pllc_top

/* test/pllc_top_tb.sv */
// Self-checking bench for the loop clock generator register block
`timescale 1ns/1ps

module pllc_top_tb;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic        wb_ack_o, osc_clock_i, vco_clock_i, lock_detect_i;
   logic        track_detect_i, base_clock_out_o, irq_o, loop_enable_o;
   logic [1:0]  bus_scaler_sel_o, vco_power_range_o;
   logic [11:0] feedback_factor_o;
   logic [7:0]  vco_range_factor_o;
   logic [3:0]  ref_divider_factor_o;
   logic        bandwidth_auto_o, bandwidth_phase_o;
   int          n_mismatch, checks_done, tick, c;
   // Rows: {write, address, data or expected read}
   logic [16:0] rows [$] = {17'h00020, 17'h00400, 17'h00800, 17'h00C40,
      17'h01040, 17'h01401, 17'h10C00, 17'h00C40, 17'h11000, 17'h01040,
      17'h11400, 17'h01401, 17'h1002D, 17'h00020, 17'h100A0, 17'h00020,
      17'h10000, 17'h00000, 17'h1001E, 17'h0000E, 17'h1002E, 17'h1003E,
      17'h0003E, 17'h1001E, 17'h0003E, 17'h1002E, 17'h1000E, 17'h0000E,
      17'h11000, 17'h1002E, 17'h1003E, 17'h0002E, 17'h1000E, 17'h11040,
      17'h01040, 17'h10C00, 17'h11400, 17'h01400, 17'h10420, 17'h00420,
      17'h104A0, 17'h00480, 17'h10400, 17'h00420, 17'h10480, 17'h00480};

   pllc_top u_pllc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .osc_clock_i(osc_clock_i),
      .vco_clock_i(vco_clock_i), .lock_detect_i(lock_detect_i),
      .track_detect_i(track_detect_i), .base_clock_out_o(base_clock_out_o),
      .irq_o(irq_o), .loop_enable_o(loop_enable_o),
      .bus_scaler_sel_o(bus_scaler_sel_o),
      .vco_power_range_o(vco_power_range_o),
      .feedback_factor_o(feedback_factor_o),
      .vco_range_factor_o(vco_range_factor_o),
      .ref_divider_factor_o(ref_divider_factor_o),
      .bandwidth_auto_o(bandwidth_auto_o),
      .bandwidth_phase_o(bandwidth_phase_o));

   // 50 MHz system clock
   always #10 clk_i = ~clk_i;

   // Slow source pins: oscillator every 5 edges, VCO every 3 edges
   always @(posedge clk_i) begin
      tick <= tick + 1;
      if (tick % 5 == 4) osc_clock_i <= ~osc_clock_i;
      if (tick % 3 == 2) vco_clock_i <= ~vco_clock_i;
   end

   // Verdict and end of run
   task tally_and_finish;
      if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   // One comparison, reported at once on mismatch
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Classic single Wishbone cycle, bounded wait on ack
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1; wb_stb_i <= 1'h1; wb_we_i <= w;
      wb_adr_i <= a; wb_dat_i <= {24'h0, d}; wb_sel_i <= 4'h1;
      i = 0;
      do begin @(posedge clk_i); i++; end while (wb_ack_o !== 1'h1 && i < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0; wb_stb_i <= 1'h0; wb_we_i <= 1'h0;
      if (i == 20) begin n_mismatch++; tally_and_finish(); end
   endtask : wb

   // Read and compare one register
   task rc(input logic [7:0] a, input logic [7:0] e);
      wb(1'h0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask : rc

   // Rising edges of the base clock over n system cycles
   task cnt(input int n);
      logic p;
      c = 0;
      p = base_clock_out_o;
      repeat (n) begin
         @(posedge clk_i);
         if (base_clock_out_o === 1'h1 && p === 1'h0) c++;
         p = base_clock_out_o;
      end
   endtask : cnt

   initial begin
      clk_i = 0; rst_i = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0;
      wb_adr_i = 0; wb_sel_i = 0; wb_dat_i = 0; lock_detect_i = 0;
      track_detect_i = 0; osc_clock_i = 0; vco_clock_i = 0; tick = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      chk({feedback_factor_o, vco_range_factor_o, ref_divider_factor_o},
          32'h00040401);
      // Table of register accesses, in order
      foreach (rows[k]) begin
         if (rows[k][16]) begin
            wb(1'h1, rows[k][15:8], rows[k][7:0]);
         end else begin
            rc(rows[k][15:8], rows[k][7:0]);
         end
      end
      // Scaler, exponent and bandwidth outputs follow the registers
      chk({26'h0, bus_scaler_sel_o, vco_power_range_o, bandwidth_auto_o,
           bandwidth_phase_o}, 32'h0000003A);
      chk({feedback_factor_o, ref_divider_factor_o, loop_enable_o},
          32'h00000022);
      wb(1'h1, 8'h00, 8'h2E);
      wb(1'h1, 8'h00, 8'hAE);
      rc(8'h00, 8'hAE);
      // Lock change in auto mode raises flag and request
      lock_detect_i <= 1'h1;
      track_detect_i <= 1'h1;
      repeat (8) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h1);
      rc(8'h00, 8'hEE);
      rc(8'h00, 8'hAE);
      repeat (3) @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      rc(8'h04, 8'hE0);
      // Oscillator halved, then VCO halved after switch-over
      cnt(240);
      chk({31'h0, c >= 11 && c <= 13}, 32'h1);
      wb(1'h1, 8'h00, 8'hBE);
      repeat (40) @(posedge clk_i);
      cnt(240);
      chk({31'h0, c >= 19 && c <= 21}, 32'h1);
      // Manual mode hides flag, enable and lock
      wb(1'h1, 8'h00, 8'hAE);
      wb(1'h1, 8'h04, 8'h00);
      lock_detect_i <= 1'h0;
      repeat (8) @(posedge clk_i);
      rc(8'h00, 8'h2E);
      rc(8'h04, 8'h00);
      chk({31'h0, irq_o}, 32'h0);
      // Reset in mid-run
      rst_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      rc(8'h00, 8'h20);
      tally_and_finish();
   end
endmodule : pllc_top_tb
